// File: common/ssrc_pkg.sv
// Overview of operation
// - 8-bit register at 0x12, resets to zero, fields 7:5, 4, 3:0.
// - both rate fields read according to power mode 0x1C bits 6:4.
// - watch codes 0000 and 0100 give 6 or 7 Hz; codes 0001 and 0010 sub-hertz.
// - 1101, 1110 never valid; 1001-1011 not precision; 1100 ultra-low only.
// - idle clock field selects eight rising rates, code 111 highest.
//
package ssrc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] SSRC_IDX_RATE   = 8'h12;
  localparam logic [7:0] SSRC_IDX_PMODE  = 8'h1C;
  localparam logic [7:0] SSRC_IDX_STATUS = 8'h40;
  localparam logic [7:0] SSRC_RATE_RST   = 8'h00;
  localparam logic [7:0] SSRC_RATE_WMASK = 8'hEF;
  localparam logic [7:0] SSRC_PMODE_RST  = 8'h00;
  localparam int         SSRC_IDLE_HI    = 7;
  localparam int         SSRC_IDLE_LO    = 5;
  localparam int         SSRC_WATCH_HI   = 3;
  localparam int         SSRC_PM_HI      = 6;
  localparam int         SSRC_PM_LO      = 4;
  // ****************************************
  // power modes
  // ****************************************
  localparam logic [2:0] SSRC_PM_ULP  = 3'h3;
  localparam logic [2:0] SSRC_PM_LP   = 3'h0;
  localparam logic [2:0] SSRC_PM_PREC = 3'h4;
  // ****************************************
  // timing: 40 MHz clock, rates in tenths of hertz
  // ****************************************
  localparam int unsigned SSRC_CLK_HZ  = 40000000;
  localparam int unsigned SSRC_DECI    = 10;
  localparam int unsigned SSRC_TICK_DIV = SSRC_CLK_HZ * SSRC_DECI;
  localparam logic [1:0] SSRC_RESP_OK     = 2'h0;
  localparam logic [1:0] SSRC_RESP_SLVERR = 2'h2;

  // watch rate in deci-hertz, zero when unavailable
  function automatic logic [15:0] ssrc_watch_dhz(input logic [3:0] c,
                                                 input logic [2:0] pm);
    logic [15:0] u;
    logic [15:0] l;
    logic [15:0] p;
    u = 16'h0000;
    l = 16'h0000;
    p = 16'h0000;
    case (c)
      4'h0, 4'h4: begin u = 16'd60; l = 16'd70; p = 16'd70; end
      4'h1: begin u = 16'd4; l = 16'd4; p = 16'd2; end
      4'h2: begin u = 16'd8; l = 16'd8; p = 16'd4; end
      4'h3: begin u = 16'd15; l = 16'd15; p = 16'd9; end
      4'h5: begin u = 16'd130; l = 16'd140; p = 16'd140; end
      4'h6: begin u = 16'd250; l = 16'd280; p = 16'd280; end
      4'h7: begin u = 16'd500; l = 16'd540; p = 16'd550; end
      4'h8: begin u = 16'd1000; l = 16'd1050; p = 16'd800; end
      4'h9: begin u = 16'd1900; l = 16'd2100; end
      4'hA: begin u = 16'd3800; l = 16'd4000; end
      4'hB: begin u = 16'd7500; l = 16'd6000; end
      4'hC: begin u = 16'd11000; end
      4'hF: begin u = 16'd13000; l = 16'd7500; p = 16'd1000; end
      default: begin u = 16'h0000; end
    endcase
    case (pm)
      SSRC_PM_ULP:  ssrc_watch_dhz = u;
      SSRC_PM_PREC: ssrc_watch_dhz = p;
      default:      ssrc_watch_dhz = l;
    endcase
  endfunction : ssrc_watch_dhz

  // idle clock rate in deci-hertz
  function automatic logic [15:0] ssrc_idle_dhz(input logic [2:0] c,
                                                input logic [2:0] pm);
    logic [15:0] u;
    logic [15:0] l;
    logic [15:0] p;
    case (c)
      3'h0: begin u = 16'd10; l = 16'd5; p = 16'd1; end
      3'h1: begin u = 16'd30; l = 16'd10; p = 16'd2; end
      3'h2: begin u = 16'd50; l = 16'd30; p = 16'd4; end
      3'h3: begin u = 16'd100; l = 16'd60; p = 16'd8; end
      3'h4: begin u = 16'd230; l = 16'd120; p = 16'd15; end
      3'h5: begin u = 16'd450; l = 16'd240; p = 16'd30; end
      3'h6: begin u = 16'd900; l = 16'd480; p = 16'd50; end
      default: begin u = 16'd1800; l = 16'd1000; p = 16'd100; end
    endcase
    case (pm)
      SSRC_PM_ULP:  ssrc_idle_dhz = u;
      SSRC_PM_PREC: ssrc_idle_dhz = p;
      default:      ssrc_idle_dhz = l;
    endcase
  endfunction : ssrc_idle_dhz
endpackage : ssrc_pkg

// File: hdl/ssrc_rate_decode.sv
module ssrc_rate_decode
  import ssrc_pkg::*;
(
  // selection
  input  wire logic [7:0]  rate_reg,
  input  wire logic [2:0]  power_mode,
  // decoded periods
  output logic      [31:0] watch_period,
  output logic      [31:0] idle_period,
  output logic             watch_valid
);
  logic [15:0] w_dhz;
  logic [15:0] i_dhz;

  always_comb begin
    w_dhz = ssrc_watch_dhz(rate_reg[SSRC_WATCH_HI:0], power_mode);
    i_dhz = ssrc_idle_dhz(rate_reg[SSRC_IDLE_HI:SSRC_IDLE_LO],
                          power_mode);
    watch_valid  = (w_dhz != 16'h0000);
    // unavailable codes park the watch timer at idle speed
    watch_period = watch_valid ? SSRC_TICK_DIV / 32'(w_dhz)
                               : SSRC_TICK_DIV / 32'(i_dhz);
    idle_period  = SSRC_TICK_DIV / 32'(i_dhz);
  end
endmodule : ssrc_rate_decode

// File: hdl/ssrc_tick_gen.sv
module ssrc_tick_gen
  import ssrc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // period in clocks
  input  wire logic [31:0] period,
  // trigger
  output logic             tick
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;

  // a shorter period wraps at once, so a new rate acts without waiting
  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r + 32'h00000001;
    if (cnt_r + 32'h00000001 >= period) begin
      cnt_nxt  = 32'h00000000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r  <= 32'h00000000;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule : ssrc_tick_gen

// File: hdl/ssrc_top.sv
module ssrc_top
  import ssrc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // rate generator side
  input  wire logic        standby_active,
  output logic             sample_trigger,
  output logic [2:0]       power_mode_out
);
  // ****************************************
  // register state
  // ****************************************
  logic [7:0]  rate_r;
  logic [7:0]  rate_nxt;
  logic [7:0]  pmode_r;
  logic [7:0]  pmode_nxt;
  logic [31:0] awaddr_r;
  logic [31:0] awaddr_nxt;
  logic        aw_have_r;
  logic        aw_have_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic [3:0]  wstrb_r;
  logic [3:0]  wstrb_nxt;
  logic        w_have_r;
  logic        w_have_nxt;
  logic        bvalid_r;
  logic        bvalid_nxt;
  logic [1:0]  bresp_r;
  logic [1:0]  bresp_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_r;
  logic [1:0]  rresp_nxt;
  logic        awready_r;
  logic        awready_nxt;
  logic        wready_r;
  logic        wready_nxt;
  logic        arready_r;
  logic        arready_nxt;
  logic [2:0]  stby_sync_r;
  logic [2:0]  stby_sync_nxt;
  logic        stby_r;
  logic        stby_nxt;
  logic        trig_r;
  logic        trig_nxt;
  logic        watch_valid;
  logic [31:0] watch_period;
  logic [31:0] idle_period;
  logic [31:0] period_sel;
  logic        tick;

  function automatic logic [7:0] ssrc_word_idx(input logic [31:0] a);
    ssrc_word_idx = a[9:2];
  endfunction : ssrc_word_idx

  // upper or low address bits set would otherwise alias a register
  function automatic logic ssrc_addr_ok(input logic [31:0] a);
    ssrc_addr_ok = (a[31:10] == 22'h000000) && (a[1:0] == 2'b00);
  endfunction : ssrc_addr_ok

  // ****************************************
  // write channel capture
  // ****************************************
  logic       do_write;
  logic [7:0] widx;

  assign do_write = aw_have_r && w_have_r && !bvalid_r;

  // address and data are held until both are in, in either order
  always_comb begin
    awaddr_nxt  = awaddr_r;
    aw_have_nxt = aw_have_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    w_have_nxt  = w_have_r;
    if (s_axi_awvalid && awready_r) begin
      awaddr_nxt  = s_axi_awaddr;
      aw_have_nxt = 1'b1;
    end
    if (s_axi_wvalid && wready_r) begin
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
      w_have_nxt = 1'b1;
    end
    if (do_write) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
    end
    // readies registered so the bus sees plain flop outputs
    awready_nxt = !aw_have_nxt && !bvalid_nxt;
    wready_nxt  = !w_have_nxt && !bvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r  <= 32'h00000000;
      aw_have_r <= 1'b0;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      w_have_r  <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
    end else begin
      awaddr_r  <= awaddr_nxt;
      aw_have_r <= aw_have_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      w_have_r  <= w_have_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
    end
  end

  // ****************************************
  // register update and write response
  // ****************************************
  always_comb begin
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rate_nxt   = rate_r;
    pmode_nxt  = pmode_r;
    widx       = ssrc_word_idx(awaddr_r);
    if (do_write) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = SSRC_RESP_OK;
      if (!ssrc_addr_ok(awaddr_r)) begin
        // refused rather than folded onto a register
        bresp_nxt = SSRC_RESP_SLVERR;
      end else begin
        case (widx)
          SSRC_IDX_RATE: begin
            // reserved bit 4 forced to zero whatever the host sends
            if (wstrb_r[0]) begin
              rate_nxt = wdata_r[7:0] & SSRC_RATE_WMASK;
            end
          end
          SSRC_IDX_PMODE: begin
            if (wstrb_r[0]) begin
              pmode_nxt = wdata_r[7:0];
            end
          end
          SSRC_IDX_STATUS: begin
            bresp_nxt = SSRC_RESP_OK;
          end
          default: begin
            bresp_nxt = SSRC_RESP_SLVERR;
          end
        endcase
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= SSRC_RESP_OK;
      rate_r   <= SSRC_RATE_RST;
      pmode_r  <= SSRC_PMODE_RST;
    end else begin
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rate_r   <= rate_nxt;
      pmode_r  <= pmode_nxt;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] ridx;

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    ridx       = ssrc_word_idx(s_axi_araddr);
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = SSRC_RESP_OK;
      rdata_nxt  = 32'h00000000;
      // unmapped or aliased words read back zero with an error
      if (!ssrc_addr_ok(s_axi_araddr)) begin
        rresp_nxt = SSRC_RESP_SLVERR;
      end else begin
        case (ridx)
          SSRC_IDX_RATE:   rdata_nxt = {24'h000000, rate_r};
          SSRC_IDX_PMODE:  rdata_nxt = {24'h000000, pmode_r};
          SSRC_IDX_STATUS: rdata_nxt = {30'h00000000, stby_r, watch_valid};
          default: begin
            rresp_nxt = SSRC_RESP_SLVERR;
          end
        endcase
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= SSRC_RESP_OK;
      arready_r <= 1'b1;
    end else begin
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      arready_r <= arready_nxt;
    end
  end

  // ****************************************
  // rate selection and trigger
  // ****************************************
  // standby flag from outside the domain: three stages, agree on last two
  always_comb begin
    stby_sync_nxt = {stby_sync_r[1:0], standby_active};
    stby_nxt      = stby_r;
    if (stby_sync_r[2] == stby_sync_r[1]) begin
      stby_nxt = stby_sync_r[2];
    end
    trig_nxt = tick;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stby_sync_r <= 3'h0;
      stby_r      <= 1'b0;
      trig_r      <= 1'b0;
    end else begin
      stby_sync_r <= stby_sync_nxt;
      stby_r      <= stby_nxt;
      trig_r      <= trig_nxt;
    end
  end

  ssrc_rate_decode u_decode (
    .rate_reg     (rate_r),
    .power_mode   (pmode_r[SSRC_PM_HI:SSRC_PM_LO]),
    .watch_period (watch_period),
    .idle_period  (idle_period),
    .watch_valid  (watch_valid)
  );

  // idle clock in standby, watch rate otherwise
  assign period_sel = stby_r ? idle_period : watch_period;

  // register only updates at write completion, so triggers keep old rate
  ssrc_tick_gen u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .period  (period_sel),
    .tick    (tick)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready  = awready_r;
  assign s_axi_wready   = wready_r;
  assign s_axi_bvalid   = bvalid_r;
  assign s_axi_bresp    = bresp_r;
  assign s_axi_arready  = arready_r;
  assign s_axi_rvalid   = rvalid_r;
  assign s_axi_rdata    = rdata_r;
  assign s_axi_rresp    = rresp_r;
  assign sample_trigger = trig_r;
  assign power_mode_out = pmode_r[SSRC_PM_HI:SSRC_PM_LO];
endmodule : ssrc_top

// File: tb/ssrc_assertions.sv
module ssrc_assertions
  import ssrc_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // rate side
  input wire logic        sample_trigger
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // read address seen at the handshake
  // ****************************************
  logic [31:0] ra_r;
  logic [31:0] ra_nxt;
  always_comb begin
    ra_nxt = ra_r;
    if (s_axi_arvalid && s_axi_arready) begin
      ra_nxt = s_axi_araddr;
    end
  end
  always_ff @(posedge aclk) begin
    ra_r <= ra_nxt;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_aw_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_trig_pulse: assert property (
    sample_trigger |=> !sample_trigger [*8])
    else $error("trigger too wide or too close");
  a_rate_read: assert property (s_axi_rvalid && ra_r == 32'h48
    |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[4]
    && s_axi_rresp == SSRC_RESP_OK) else $error("rate read wrong");
  a_unmapped_err: assert property (s_axi_rvalid
    && !(ra_r inside {32'h48, 32'h70, 32'h100})
    |-> s_axi_rresp == SSRC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : ssrc_assertions

bind ssrc_top ssrc_assertions u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .sample_trigger(sample_trigger)
);

// File: tb/ssrc_partner.sv
module ssrc_partner
(
  // clock
  input wire logic        aclk,
  // idle request and trigger
  input wire logic        idle_req,
  input wire logic        sample_trigger,
  // observation
  output logic            standby_active,
  output logic [31:0]     gap,
  output logic [7:0]      n_trig
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] cnt;
  initial begin
    standby_active = 1'b0;
    gap = 32'h0;
    n_trig = 8'h0;
    cnt = 32'h0;
  end
  // level only: the design resynchronises it
  always @(posedge aclk) begin
    standby_active <= idle_req;
    cnt <= cnt + 32'h1;
    if (sample_trigger === 1'b1) begin
      gap <= cnt + 32'h1;
      cnt <= 32'h0;
      n_trig <= n_trig + 8'h1;
    end
  end
endmodule : ssrc_partner

// File: tb/ssrc_top_tb.sv
module ssrc_top_tb;
  import ssrc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, trig, idle_req;
  logic        standby;
  logic [31:0] awaddr, wdata, araddr, rdata, gap, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  pmo;
  logic [7:0]  n_trig, k;
  int          n_fail, tests_run, cyc;
  logic [2:0]  pm [3];
  logic [7:0]  sa [14];
  logic [7:0]  sv [14];
  ssrc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .standby_active(standby), .sample_trigger(trig),
    .power_mode_out(pmo));
  ssrc_partner u_far (.aclk(aclk), .idle_req(idle_req),
    .sample_trigger(trig), .standby_active(standby), .gap(gap),
    .n_trig(n_trig));
  // ****************************************
  // bus tasks and checks
  // ****************************************
  // readies are flop-driven, so a look just after the edge holds till
  // the next edge
  task automatic wr(input logic [31:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    logic pa, pw, qa, qw, h;
    pa = 1'b1;
    pw = 1'b1;
    h = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!h) begin
      #1;
      qa = pa && awready;
      qw = pw && wready;
      h = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (qa) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (qw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    logic p, q, h;
    p = 1'b1;
    h = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    while (!h) begin
      #1;
      q = p && arready;
      h = rvalid && !p;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (q) begin
        arvalid <= 1'b0;
        p = 1'b0;
      end
    end
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %0t data %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %0t resp %h expected %h", $time, g, e);
    end
  endtask : chk_resp
  function automatic logic wv(input logic [3:0] c, input logic [2:0] m);
    wv = !(c == 4'hD || c == 4'hE || (m != SSRC_PM_ULP && c == 4'hC)
      || (m == SSRC_PM_PREC && c >= 4'h9 && c <= 4'hB));
  endfunction : wv
  task automatic summarize();
    $display("mismatches %0d of %0d checks", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      n_fail++;
      summarize();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, idle_req} = 7'h00;
    {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
    wstrb = 4'hF;
    cyc = 0;
    n_fail = 0;
    tests_run = 0;
    pm = '{SSRC_PM_PREC, SSRC_PM_LP, SSRC_PM_ULP};
    sa = '{8'h10, 8'h15, 8'h16, 8'h1C, 8'h11, 8'h29, 8'h11,
           8'h29, 8'h11, 8'h29, 8'h11, 8'h29, 8'h11, 8'h10};
    sv = '{8'h01, 8'h04, 8'h5D, 8'h30, 8'h10, 8'h30, 8'h30,
           8'h01, 8'h60, 8'h52, 8'h70, 8'h01, 8'h0F, 8'h02};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(32'h48, d, r);
    chk(d, {24'h0, SSRC_RATE_RST});
    rd(32'h70, d, r);
    chk(d, {24'h0, SSRC_PMODE_RST});
    rd(32'h44, d, r);
    chk_resp(r, SSRC_RESP_SLVERR);
    wr(32'h48, 32'hEF, r);
    rd(32'h48, d, r);
    chk(d, 32'hEF);
    // ulp column of the top-rate setup; only 0x1C is mapped here
    for (int i = 0; i < 14; i++) begin
      wr({22'h0, sa[i], 2'b00}, {24'h0, sv[i]}, r);
      chk_resp(r, sa[i] == 8'h1C ? SSRC_RESP_OK : SSRC_RESP_SLVERR);
    end
    chk({29'h0, pmo}, {29'h0, SSRC_PM_ULP});
    wr(32'h48, 32'h0F, r);
    chk_resp(r, SSRC_RESP_OK);
    k = n_trig;
    while (n_trig != k + 8'h2) @(posedge aclk);
    chk(gap, SSRC_TICK_DIV / 32'd13000);
    idle_req <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(32'h100, d, r);
    chk(d & 32'h2, 32'h2);
    idle_req <= 1'b0;
    foreach (pm[j]) begin
      wr(32'h70, {25'h0, pm[j], 4'h0}, r);
      for (int c = 0; c < 16; c++) begin
        wr(32'h48, {24'h0, 4'hE, c[3:0]}, r);
        rd(32'h48, d, r);
        chk(d, {24'h0, 4'hE, c[3:0]});
        rd(32'h100, d, r);
        chk({31'h0, d[0]}, {31'h0, wv(c[3:0], pm[j])});
      end
      chk({29'h0, pmo}, {29'h0, pm[j]});
    end
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(32'h48, d, r);
    chk(d, {24'h0, SSRC_RATE_RST});
    summarize();
  end
endmodule : ssrc_top_tb
